// [logic/one_wire_brightness_dev.sv]
/*
  Device end: decodes self-timed 24-bit commands on the wire, applies a
  9-bit brightness level and answers with a pull-down when asked.
  Assumes one 100 MHz clock and a controller that keeps bit low phases
  shorter than the end-of-stream time.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wire_link_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RULE1] 24-bit words, least significant bit first
// [RULE2] controller holds line high before start
// [RULE3] line already high: first fall starts bits
// [RULE4] controller holds end-of-stream after last bit
// [RULE5] bit value from low/high ratio of two
// [RULE6] bit period runs fall to fall
// [RULE7] acknowledge needs request, address match, 24 bits
// [RULE8] wait validation delay, then bounded pull-down
// [RULE9] controller holds low, then releases and samples
// [RULE10] sampled low means command accepted
// [RULE11] controller waits for pull-down end
// [RULE12] only open-drain controllers request acknowledge
// [RULE13] word bits 0-6 are brightness 0-6
// [RULE14] bits 23-16 hold device address 0x8f
// [RULE15] bit 10 requests the acknowledge
// [RULE16] word bits 8-7 are brightness 8-7
// [RULE17] controller sends zero in unused bits
// [RULE18] apply level only from complete matching words
// [RULE19] sample line, time phases with counters
module one_wire_brightness_dev
  import wire_link_pkg::*;
#(
  parameter int ACK_PULSE_CYCLES = `ACK_PULSE_TIME_CYCLES,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // wire to the controller
  one_wire_if.device LINK,
  // user side
  output brightness_type BRIGHTNESS_O,
  output logic LEVEL_STROBE_O,
  output logic REJECT_O
);

  //////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ACK_PULSE_CYCLES < 1 || ACK_PULSE_CYCLES > 2 ** CNT_W) begin : g_chk_pulse
    $error("pulse length does not fit the counter");
  end
  if (`ACK_VALIDATION_DELAY_CYCLES <= `STREAM_END_HOLD_CYCLES) begin : g_chk_val
    $error("validation delay must exceed end-of-stream time");
  end

  localparam logic [CNT_W-1:0] START_CNT = CNT_W'(`START_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] EOS_CNT = CNT_W'(`STREAM_END_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] VAL_CNT = CNT_W'(`ACK_VALIDATION_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(ACK_PULSE_CYCLES - 1);
  localparam logic [4:0] FULL_BITS = 5'(`WORD_BITS);

  logic line_meta;
  logic line_sync;
  logic line_prev;
  dev_state_type state;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] pulse_cnt;
  logic [4:0] bit_cnt;
  word_type shift_word;
  logic bad_bit;

  //////////////////////////////////////////////////////////////////////////
  // line synchroniser, edges seen on the second stage only
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      line_meta <= LINK.line; // [RULE19]
      line_sync <= line_meta;
      line_prev <= line_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge, counter and word decode
  wire fall = line_prev & ~line_sync;
  wire rise = ~line_prev & line_sync;
  wire [CNT_W-1:0] low_inc = (&low_cnt) ? low_cnt : low_cnt + 1'b1;
  wire [CNT_W-1:0] high_inc = (&high_cnt) ? high_cnt : high_cnt + 1'b1;
  wire bit_zero = {1'b0, low_cnt} >= {high_cnt, 1'b0}; // [RULE5]
  wire bit_one = {1'b0, high_cnt} >= {low_cnt, 1'b0}; // [RULE5]
  wire bit_ok = bit_zero | bit_one;
  wire [4:0] bit_inc = (&bit_cnt) ? bit_cnt : bit_cnt + 1'b1;
  wire addr_match = shift_word[`ADDR_MSB:`ADDR_LSB] == `DEV_ADDRESS; // [RULE14]
  wire word_ok = (bit_cnt == FULL_BITS) & ~bad_bit & addr_match; // [RULE18]
  wire ack_due = word_ok & shift_word[`ACK_REQ_BIT]; // [RULE7] [RULE15]
  wire eos_seen = ~line_sync & (low_cnt >= EOS_CNT);

  //////////////////////////////////////////////////////////////////////////
  // receive sequencer
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= DEV_IDLE;
      low_cnt <= '0;
      high_cnt <= '0;
      pulse_cnt <= '0;
      bit_cnt <= '0;
      shift_word <= '0;
      bad_bit <= 1'b0;
      BRIGHTNESS_O <= `BRIGHTNESS_RESET;
      LEVEL_STROBE_O <= 1'b0;
      REJECT_O <= 1'b0;
      LINK.dev_pull_oe <= 1'b0;
    end else begin
      LEVEL_STROBE_O <= 1'b0;
      REJECT_O <= 1'b0;
      unique case (state)
        // line must have been high for the start time
        DEV_IDLE: begin
          high_cnt <= line_sync ? high_inc : '0;
          if (line_sync && high_cnt >= START_CNT) begin
            state <= DEV_READY;
          end
        end

        // high and armed: the first fall opens bit one
        DEV_READY: begin
          if (fall) begin // [RULE3]
            state <= DEV_LOW;
            low_cnt <= '0;
            bit_cnt <= '0;
            bad_bit <= 1'b0;
          end
        end

        // low phase; a long low closes the stream
        DEV_LOW: begin
          low_cnt <= low_inc; // [RULE19]
          if (rise) begin
            state <= DEV_HIGH;
            high_cnt <= '0;
          end else if (eos_seen) begin
            if (word_ok) begin
              BRIGHTNESS_O <= shift_word[`BRIGHT_MSB:0]; // [RULE13] [RULE16] [RULE18]
              LEVEL_STROBE_O <= 1'b1;
            end else begin
              REJECT_O <= 1'b1; // [RULE18]
            end
            if (ack_due) begin
              state <= DEV_ACK_WAIT; // [RULE7]
            end else begin
              state <= DEV_IDLE;
              high_cnt <= '0;
            end
          end
        end

        // high phase; the next fall ends and decodes the bit
        DEV_HIGH: begin
          high_cnt <= high_inc;
          if (fall) begin // [RULE6]
            shift_word <= {bit_one, shift_word[`WORD_BITS-1:1]}; // [RULE1]
            bad_bit <= bad_bit | ~bit_ok;
            bit_cnt <= bit_inc;
            low_cnt <= '0;
            state <= DEV_LOW;
          end else if (high_cnt >= START_CNT) begin
            // idle high mid-word: drop the partial word, stay armed
            REJECT_O <= 1'b1; // [RULE18]
            state <= DEV_READY; // [RULE3]
          end
        end

        // validation delay counted from the last fall
        DEV_ACK_WAIT: begin
          low_cnt <= low_inc;
          if (low_cnt >= VAL_CNT) begin // [RULE8]
            LINK.dev_pull_oe <= 1'b1;
            pulse_cnt <= '0;
            state <= DEV_ACK_PULL;
          end
        end

        // pull-down held for the pulse length, never longer
        DEV_ACK_PULL: begin
          pulse_cnt <= pulse_cnt + 1'b1;
          if (pulse_cnt >= PULSE_CNT) begin // [RULE8]
            LINK.dev_pull_oe <= 1'b0;
            high_cnt <= '0;
            state <= DEV_IDLE;
          end
        end
        default: begin
          LINK.dev_pull_oe <= 1'b0;
          state <= DEV_IDLE;
        end
      endcase
    end
  end

endmodule : one_wire_brightness_dev

`default_nettype wire

// [logic/one_wire_brightness_host.sv]
/*
  Controller end: takes a brightness command over AXI4-Lite, sends it
  as a self-timed 24-bit word and listens for the acknowledge.
  Assumes one 100 MHz clock and the device's pull-down on the wire.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wire_link_regs.svh"

module one_wire_brightness_host
  import wire_link_pkg::*;
#(
  parameter int ACK_PULSE_CYCLES = `ACK_PULSE_TIME_CYCLES,
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // write address and data
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [3:0] AWADDR_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  // write response
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  // read
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [3:0] ARADDR_I,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  // wire to the device
  one_wire_if.host LINK
);

  //////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (ACK_PULSE_CYCLES <= `ACK_SETTLE_CYCLES || ACK_PULSE_CYCLES > 2 ** CNT_W) begin : g_chk
    $error("pulse length does not fit the counter");
  end

  localparam logic [CNT_W-1:0] START_CNT =
    CNT_W'(`START_HOLD_CYCLES + `ACK_SETTLE_CYCLES - 1); // [RULE2]
  localparam logic [CNT_W-1:0] SHORT_CNT = CNT_W'(`BIT_UNIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_CNT = CNT_W'(3 * `BIT_UNIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] EOS_CNT =
    CNT_W'(`STREAM_END_HOLD_CYCLES + `ACK_SETTLE_CYCLES - 1); // [RULE4]
  localparam logic [CNT_W-1:0] REL_CNT = CNT_W'(`HOST_RELEASE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(`ACK_SETTLE_CYCLES);
  localparam logic [CNT_W-1:0] LISTEN_CNT = CNT_W'(ACK_PULSE_CYCLES - 1);
  localparam logic [4:0] LAST_BIT = 5'(`WORD_BITS - 1);

  logic aw_got;
  logic w_got;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  brightness_type cmd_level;
  logic cmd_ackreq;
  host_state_type state;
  logic [CNT_W-1:0] cnt;
  logic [4:0] bit_idx;
  word_type word;
  logic drive_low;
  logic busy;
  logic done;
  logic ack_seen;
  logic line_meta;
  logic line_sync;

  //////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_fire = aw_got & w_got & ~BVALID_O;
  wire wr_ok = (wr_addr == `CMD_OFFSET) & (wr_strb[1:0] == 2'b11) & ~busy;
  wire cmd_go = wr_fire & wr_ok;
  wire ack_in = wr_data[`CMD_ACKREQ_BIT] & OPEN_DRAIN; // [RULE12]
  wire [4:0] zero_bits = 5'h00;
  wire [CNT_W-1:0] cnt_inc = cnt + 1'b1;
  // unused positions sent as zero, address in the top byte
  wire [23:0] next_word = {`DEV_ADDRESS, zero_bits, ack_in, 1'b0,
                           wr_data[`BRIGHT_MSB:0]}; // [RULE14] [RULE15] [RULE17]
  wire rd_cmd = ARADDR_I == `CMD_OFFSET;
  wire rd_st = ARADDR_I == `STATUS_OFFSET;
  wire [31:0] cmd_word = {22'h000000, cmd_ackreq, cmd_level};
  wire [31:0] st_word = {28'h0000000, done, cmd_ackreq, ack_seen, busy};
  wire [31:0] rd_mux = rd_cmd ? cmd_word : (rd_st ? st_word : 32'h00000000);
  wire cur_bit = word[bit_idx];
  // zero: long low, short high; one: the reverse
  wire [CNT_W-1:0] low_len = cur_bit ? SHORT_CNT : LONG_CNT; // [RULE5]
  wire [CNT_W-1:0] high_len = cur_bit ? LONG_CNT : SHORT_CNT; // [RULE5]
  wire [CNT_W-1:0] tail_len = word[`ACK_REQ_BIT] ? REL_CNT : EOS_CNT; // [RULE9]

  //////////////////////////////////////////////////////////////////////////
  // write channels, taken in either order, answered after both
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= `AXI_RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_got <= 1'b1;
        AWREADY_O <= 1'b0;
        wr_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_got <= 1'b1;
        WREADY_O <= 1'b0;
        wr_data <= WDATA_I;
        wr_strb <= WSTRB_I;
      end
      if (wr_fire) begin
        BVALID_O <= 1'b1;
        BRESP_O <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel, data one cycle after the address
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `AXI_RESP_OKAY;
    end else begin
      if (ARVALID_I && ARREADY_O) begin
        ARREADY_O <= 1'b0;
        RVALID_O <= 1'b1;
        RDATA_O <= rd_mux;
        RRESP_O <= (rd_cmd | rd_st) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      if (RVALID_O && RREADY_I) begin
        RVALID_O <= 1'b0;
        ARREADY_O <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // line synchroniser and pin drivers
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
      LINK.host_out <= 1'b1;
      LINK.host_oe <= 1'b0;
    end else begin
      line_meta <= LINK.line;
      line_sync <= line_meta;
      LINK.host_out <= ~drive_low;
      LINK.host_oe <= drive_low | ~OPEN_DRAIN; // [RULE12]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit sequencer
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state <= HOST_IDLE;
      cnt <= '0;
      bit_idx <= 5'h00;
      word <= '0;
      drive_low <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      ack_seen <= 1'b0;
      cmd_level <= `BRIGHTNESS_RESET;
      cmd_ackreq <= 1'b0;
    end else begin
      cnt <= cnt_inc;
      unique case (state)
        HOST_IDLE: begin
          if (cmd_go) begin
            word <= next_word;
            cmd_level <= wr_data[`BRIGHT_MSB:0];
            cmd_ackreq <= ack_in;
            busy <= 1'b1;
            done <= 1'b0;
            ack_seen <= 1'b0;
            cnt <= '0;
            state <= HOST_START;
          end
        end
        // start condition: line high, released when open drain, driven high otherwise
        HOST_START: begin
          if (cnt == START_CNT) begin // [RULE2]
            drive_low <= 1'b1;
            bit_idx <= 5'h00;
            cnt <= '0;
            state <= HOST_LOW;
          end
        end
        HOST_LOW: begin
          if (cnt == low_len) begin
            drive_low <= 1'b0;
            cnt <= '0;
            state <= HOST_HIGH;
          end
        end
        // bits go out from index 0 upward
        HOST_HIGH: begin
          if (cnt == high_len) begin
            drive_low <= 1'b1;
            cnt <= '0;
            bit_idx <= bit_idx + 1'b1; // [RULE1]
            state <= (bit_idx == LAST_BIT) ? HOST_TAIL : HOST_LOW;
          end
        end
        // end of stream, extended through the validation delay only when the word requests an acknowledge
        HOST_TAIL: begin
          if (cnt == tail_len) begin // [RULE4] [RULE9]
            drive_low <= 1'b0;
            cnt <= '0;
            state <= word[`ACK_REQ_BIT] ? HOST_LISTEN : HOST_IDLE;
            busy <= word[`ACK_REQ_BIT];
            done <= ~word[`ACK_REQ_BIT];
          end
        end
        // line released; any low after settling is the acknowledge
        HOST_LISTEN: begin
          if (cnt >= SETTLE_CNT && !line_sync) begin
            ack_seen <= 1'b1; // [RULE10]
          end
          if (cnt == LISTEN_CNT) begin
            state <= HOST_DRAIN;
          end
        end
        // no new word until the pull-down has ended
        HOST_DRAIN: begin
          if (line_sync) begin // [RULE11]
            busy <= 1'b0;
            done <= 1'b1;
            state <= HOST_IDLE;
          end
        end
        default: begin
          drive_low <= 1'b0;
          busy <= 1'b0;
          state <= HOST_IDLE;
        end
      endcase
    end
  end

endmodule : one_wire_brightness_host

`default_nettype wire

// [logic/one_wire_if.sv]
/*
  The single wire between controller and device, with a pull-up.
  Assumes each end drives only its own enables.
*/
`timescale 1ns/1ps
`default_nettype none

interface one_wire_if;
  logic host_out;
  logic host_oe;
  logic dev_pull_oe;
  logic line;

  // device pull-down wins, then the controller, else the pull-up
  assign line = dev_pull_oe ? 1'b0 : (host_oe ? host_out : 1'b1);

  modport host (output host_out, output host_oe, input line);
  modport device (output dev_pull_oe, input line);
endinterface : one_wire_if

`default_nettype wire

// [logic/unused_placeholder_none.sv]
/*
  Empty unit kept out of the build; holds no logic.
  Assumes nothing.
*/
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [logic/wire_link_pkg.sv]
/*
  Types shared by both ends of the single-wire brightness link.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package wire_link_pkg;
  typedef logic [8:0] brightness_type;
  typedef logic [23:0] word_type;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_READY = 3'b001,
    DEV_LOW = 3'b010,
    DEV_HIGH = 3'b011,
    DEV_ACK_WAIT = 3'b100,
    DEV_ACK_PULL = 3'b101
  } dev_state_type;
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_START = 3'b001,
    HOST_LOW = 3'b010,
    HOST_HIGH = 3'b011,
    HOST_TAIL = 3'b100,
    HOST_LISTEN = 3'b101,
    HOST_DRAIN = 3'b110
  } host_state_type;
endpackage : wire_link_pkg

`default_nettype wire

// [logic/wire_link_regs.svh]
/*
  Constants of the single-wire brightness link: timing, word fields and
  the controller's register map. Assumes a 100 MHz clock on both ends.
*/
`ifndef WIRE_LINK_REGS_SVH
`define WIRE_LINK_REGS_SVH

// clock
`define CLK_PERIOD_NS 10
// start condition, least time, rounded up
`define START_HOLD_NS 2000
`define START_HOLD_CYCLES ((`START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// end of stream, least time, rounded up
`define STREAM_END_HOLD_NS 2000
`define STREAM_END_HOLD_CYCLES ((`STREAM_END_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// device wait from last falling edge to pull-down
`define ACK_VALIDATION_DELAY_NS 4000
`define ACK_VALIDATION_DELAY_CYCLES (`ACK_VALIDATION_DELAY_NS / `CLK_PERIOD_NS)
// controller releases the line this long after the last falling edge
`define HOST_RELEASE_NS 5000
`define HOST_RELEASE_CYCLES ((`HOST_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// pull-down length, longest time, rounded down
`define ACK_PULSE_TIME_NS 512000
`define ACK_PULSE_TIME_CYCLES (`ACK_PULSE_TIME_NS / `CLK_PERIOD_NS)
// short phase of a bit; the long phase is three of these
`define BIT_UNIT_NS 250
`define BIT_UNIT_CYCLES ((`BIT_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// margin covering the two-stage synchroniser
`define ACK_SETTLE_CYCLES 4

// command word fields
`define WORD_BITS 24
`define ADDR_MSB 23
`define ADDR_LSB 16
`define ACK_REQ_BIT 10
`define BRIGHT_MSB 8
`define DEV_ADDRESS 8'h8f
`define BRIGHTNESS_RESET 9'h000

// controller registers
`define CMD_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CMD_ACKREQ_BIT 9
`define ST_BUSY_BIT 0
`define ST_ACK_SEEN_BIT 1
`define ST_ACK_REQ_BIT 2
`define ST_DONE_BIT 3
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// [sim/tb.sv]
/*
  Testbench: controller and device on one wire, plus a second device fed
  by a bench driver. Assumes a 100 MHz clock and ACK_PULSE_CYCLES of 256.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import wire_link_pkg::*;
  localparam int ACKP = 256;
  localparam logic [23:0] WD [5] = '{24'h8e0455, 24'h8f0455, 24'h8f0455, 24'h8f05ff, 24'h8f0033};
  localparam int NB [5] = '{24, 24, 23, 24, 24};
  localparam int BAD [5] = '{-1, 3, -1, -1, -1};
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, strobe1, rej1, strobe2, rej2, pull1_q, pull2_q;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  brightness_type bright1, bright2;
  int n_mismatch, num_checks, n_strobe1, n_rej1, n_rej2, n_pull1, n_pull2;
  one_wire_if w1();
  one_wire_if w2();

  //////////////////////////////////////////////////////////////////////////////
  // design ends and checker
  one_wire_brightness_host #(.ACK_PULSE_CYCLES(ACKP)) u_one_wire_brightness_host (
    .CLK_I(clk), .RESET_N_I(rst_n), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .AWADDR_I(awaddr), .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata),
    .WSTRB_I(4'hf), .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr), .RVALID_O(rvalid),
    .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp), .LINK(w1.host));
  one_wire_brightness_dev #(.ACK_PULSE_CYCLES(ACKP)) u_one_wire_brightness_dev (
    .CLK_I(clk), .RESET_N_I(rst_n), .LINK(w1.device), .BRIGHTNESS_O(bright1),
    .LEVEL_STROBE_O(strobe1), .REJECT_O(rej1));
  one_wire_brightness_dev #(.ACK_PULSE_CYCLES(ACKP)) u_one_wire_brightness_dev_b (
    .CLK_I(clk), .RESET_N_I(rst_n), .LINK(w2.device), .BRIGHTNESS_O(bright2),
    .LEVEL_STROBE_O(strobe2), .REJECT_O(rej2));
  wire_link_assertions #(.ACK_PULSE_CYCLES(ACKP)) u_wire_link_assertions (
    .CLK_I(clk), .RESET_N_I(rst_n), .host_out(w1.host_out), .host_oe(w1.host_oe),
    .dev_pull_oe(w1.dev_pull_oe), .line(w1.line));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // event counters on both links
  always @(posedge clk) begin
    pull1_q <= w1.dev_pull_oe;
    pull2_q <= w2.dev_pull_oe;
    n_strobe1 <= n_strobe1 + int'(strobe1 === 1'b1);
    n_rej1 <= n_rej1 + int'(rej1 === 1'b1);
    n_rej2 <= n_rej2 + int'(rej2 === 1'b1);
    n_pull1 <= n_pull1 + int'(w1.dev_pull_oe === 1'b1 && pull1_q === 1'b0);
    n_pull2 <= n_pull2 + int'(w2.dev_pull_oe === 1'b1 && pull2_q === 1'b0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] res);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        res = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] res);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        res = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic wait_idle();
    do axi_rd(4'h4, d, r); while (d[0] !== 1'b0);
  endtask : wait_idle

  // bench driver of the second wire: open drain, low or released
  task automatic hold(input logic low, input int n);
    w2.host_oe <= low;
    repeat (n) @(posedge clk);
  endtask : hold

  task automatic send_word(input logic [23:0] w, input int nb, input int bad);
    @(posedge clk);
    hold(1'b0, 204);
    for (int i = 0; i < nb; i++) begin
      if (i == bad) begin
        hold(1'b1, 50);
        hold(1'b0, 50);
      end else begin
        hold(1'b1, w[i] ? 25 : 75);
        hold(1'b0, w[i] ? 75 : 25);
      end
    end
    hold(1'b1, 500);
    hold(1'b0, ACKP + 100);
  endtask : send_word

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    axi_rd(4'h4, d, r);
    chk(d, 32'h0);
    chk({23'h0, bright1}, 32'h0);
  endtask : t_reset_values

  task automatic t_plain_cmd();
    axi_wr(4'h0, 32'h155, r);
    chk({30'h0, r}, 32'h0);
    wait_idle();
    chk({23'h0, bright1}, 32'h155);
    chk(n_strobe1, 32'h1);
    chk(d, 32'h8);
    chk(n_pull1, 32'h0);
  endtask : t_plain_cmd

  task automatic t_ack_cmd();
    axi_wr(4'h0, 32'h2aa, r);
    axi_wr(4'h0, 32'h011, r);
    chk({30'h0, r}, 32'h2);
    axi_wr(4'h4, 32'h0, r);
    chk({30'h0, r}, 32'h2);
    wait_idle();
    chk({23'h0, bright1}, 32'h0aa);
    chk(d, 32'he);
    chk(n_pull1, 32'h1);
    axi_rd(4'h0, d, r);
    chk(d, 32'h2aa);
    axi_rd(4'h8, d, r);
    chk({d[29:0], r}, 32'h2);
    chk(n_rej1, 32'h0);
  endtask : t_ack_cmd

  task automatic t_bad_words();
    for (int i = 0; i < 5; i++) begin
      send_word(WD[i], NB[i], BAD[i]);
      chk(n_rej2, (i < 3) ? i + 1 : 3);
      chk(n_pull2, (i < 3) ? 0 : 1);
      chk({23'h0, bright2}, (i < 3) ? 32'h0 : {23'h0, WD[i][8:0]});
    end
  endtask : t_bad_words

  //////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // watchdog against a hang
  initial begin
    #1000000;
    n_mismatch++;
    end_of_test();
  end

  // main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {n_mismatch, num_checks, n_strobe1, n_rej1, n_rej2, n_pull1, n_pull2} = '0;
    w2.host_oe = 1'b0;
    w2.host_out = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_plain_cmd();
    t_ack_cmd();
    t_bad_words();
    end_of_test();
  end
endmodule : tb

`default_nettype wire

// [sim/wire_link_assertions.sv]
/*
  Checker for one single-wire link: run lengths, bit shape, pull-down.
  Assumes the interface signals of a link joined by two design ends.
*/
`timescale 1ns/1ps
`default_nettype none

module wire_link_assertions #(
  parameter int ACK_PULSE_CYCLES = 64
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // wire signals
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic dev_pull_oe,
  input wire logic line
);
  logic [19:0] hi_cnt;
  logic [19:0] lo_cnt;
  logic [19:0] last_lo;
  logic [19:0] pull_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // run lengths of each line level and of the pull-down
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hi_cnt <= '0;
      lo_cnt <= '0;
      last_lo <= '0;
      pull_cnt <= '0;
    end else begin
      hi_cnt <= line ? hi_cnt + 20'h1 : 20'h0;
      lo_cnt <= line ? 20'h0 : lo_cnt + 20'h1;
      last_lo <= (line && lo_cnt != 20'h0) ? lo_cnt : last_lo;
      pull_cnt <= dev_pull_oe ? pull_cnt + 20'h1 : 20'h0;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  //////////////////////////////////////////////////////////////////////////////
  // sequences and properties
  sequence s_ack_begin;
    $rose(dev_pull_oe);
  endsequence
  sequence s_tail_end;
    $fell(host_oe) && lo_cnt > 20'd100;
  endsequence
  sequence s_frame_fall;
    $rose(host_oe) && hi_cnt > 20'd100;
  endsequence
  property p_pull_max;
    pull_cnt <= 20'(ACK_PULSE_CYCLES);
  endproperty
  property p_pull_exact;
    $fell(dev_pull_oe) |-> $past(pull_cnt) == 20'(ACK_PULSE_CYCLES) - 20'h1;
  endproperty
  property p_pull_delay;
    s_ack_begin |-> lo_cnt >= 20'd396 && lo_cnt <= 20'd412;
  endproperty
  property p_start_hold;
    s_frame_fall |-> hi_cnt >= 20'd200;
  endproperty
  property p_tail_hold;
    s_tail_end |-> lo_cnt >= 20'd200;
  endproperty
  property p_bit_ratio;
    $rose(host_oe) && hi_cnt < 20'd100 |->
      (last_lo >= 20'd2 * hi_cnt) || (hi_cnt >= 20'd2 * last_lo);
  endproperty
  property p_quiet_in_ack;
    dev_pull_oe |-> !$rose(host_oe);
  endproperty
  property p_open_drain;
    host_oe |-> !host_out;
  endproperty

  a_pull_max: assert property (p_pull_max) else $error("pull-down too long");
  a_pull_exact: assert property (p_pull_exact) else $error("pull-down length off");
  a_pull_delay: assert property (p_pull_delay) else $error("pull-down delay off");
  a_start_hold: assert property (p_start_hold) else $error("start high too short");
  a_tail_hold: assert property (p_tail_hold) else $error("end of stream too short");
  a_bit_ratio: assert property (p_bit_ratio) else $error("bit ratio below two");
  a_quiet_in_ack: assert property (p_quiet_in_ack) else $error("drive during pull");
  a_open_drain: assert property (p_open_drain) else $error("wire driven high");
endmodule : wire_link_assertions

`default_nettype wire
